// ==== logic/nvmcd_pkg.sv ====
// Package for the nvm clock divider and option block.
// Assumes an APB slave with 32-bit data, one register per aligned word.
package nvmcd_pkg;
  // Register byte addresses
  localparam logic [11:0] ADDR_DIVIDER = 12'h000;
  localparam logic [11:0] ADDR_OPTION = 12'h004;
  localparam logic [11:0] ADDR_KEY = 12'h008;
  localparam logic [11:0] ADDR_KEYCTL = 12'h00c;
  localparam logic [11:0] ADDR_STATUS = 12'h010;
  // Divider register fields
  localparam int DIV_LOADED_BIT = 7;
  localparam int DIV_PRESCALE_BIT = 6;
  localparam int DIV_MSB = 5;
  // Option register fields
  localparam int OPT_BACKDOOR_KEY_ENABLE_BIT = 7;
  localparam int OPT_NORED_BIT = 6;
  localparam int OPT_SECMODE_BIT = 5;
  // Security code that leaves the device open
  localparam logic [1:0] SEC_UNSECURED = 2'h2;
  // Prescale stage divides by eight
  localparam logic [2:0] PRESCALE_LAST = 3'h7;
  // Index of the last key byte; the key is eight bytes
  localparam logic [2:0] KEY_LAST = 3'h7;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  // Memory clock bounds, in kHz, for software guidance
  localparam int NVM_CLK_MIN_KHZ = 150;
  localparam int NVM_CLK_MAX_KHZ = 200;
  // Option bits decoded for the rest of the device
  typedef struct packed {
    logic key_enable;
    logic redirection_disable;
    logic eeprom_sector_mode;
    logic secure;
  } nvmcd_opt_t;
  // Key-entry state machine, Gray along the usual path
  typedef enum logic [1:0] {
    KS_IDLE = 2'b00,
    KS_ENTER = 2'b01,
    KS_CHECK = 2'b10,
    KS_FAIL = 2'b11
  } nvmcd_key_state_t;
endpackage

// ==== logic/nvmcd_top.sv ====
// Clock divider and option register block for the nvm controller.
// Assumes APB master on sys_clk; option byte and key come from nvm array.
//
// What this block does
// - Loaded flag bit 7 is read-only, reset clears, first divider write sets
// - Divider low seven bits always readable, written only once after reset
// - Program and erase blocked until loaded flag is one
// - Prescale bit 6 set feeds divider with bus clock divided by eight
// - Divider divides its input by six-bit field plus one
// - Each timing pulse is one memory clock period; whole pulses only
// - Option copy loaded from stored byte during every reset
// - Key enable zero forbids backdoor unlock; matching key unlocks till reset
// - Key writes from debug or unsecure code never unlock
// - Option bit 6 set disables vector redirection
// - Option bit 5 picks split-page or single-page EEPROM sectors
// - Only security code one-zero leaves device unsecured
// - Secure device refuses memory access from unsecured sources
// - Key success or full blank check sets security code to one-zero
// - Blocked secure write ignored, blocked read returns zeros
// - Key access set makes key writes comparisons, else command start
//
// Chosen here: the APB register port and the placing of the registers.
`timescale 1ns/1ps
module nvmcd_top (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] stored_option_byte,
  input wire logic [63:0] stored_backdoor_key,
  input wire logic access_from_secure,
  input wire logic blank_check_ok,
  input wire logic mem_req,
  input wire logic mem_from_secure,
  input wire logic [7:0] mem_rdata_raw,
  output logic mem_grant,
  output logic [7:0] mem_rdata,
  output logic nvm_clk_en,
  output logic pgm_erase_enable,
  output logic cmd_start,
  output nvmcd_pkg::nvmcd_opt_t opt_out
);
  logic [7:0] div_reg;
  logic [7:0] opt_reg;
  logic key_access_reg;
  logic [2:0] key_idx_reg;
  logic key_match_reg;
  nvmcd_pkg::nvmcd_key_state_t key_state_reg;
  logic [2:0] pre_cnt_reg;
  logic [5:0] div_cnt_reg;
  logic rst_seen_reg;
  logic wr_acc;
  logic rd_acc;
  logic pre_tick;
  logic is_secure;

  // Decode of the security code, used in several places
  function automatic logic secure_of(input logic [1:0] code);
    secure_of = (code != nvmcd_pkg::SEC_UNSECURED);
  endfunction

  // Zero-wait APB: every access finishes in its first access cycle
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;
  assign is_secure = secure_of(opt_reg[1:0]);

  // Divider register: one write locks value and sets flag
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
      div_reg <= nvmcd_pkg::RESET_BYTE;
    else if (wr_acc && paddr == nvmcd_pkg::ADDR_DIVIDER
             && !div_reg[nvmcd_pkg::DIV_LOADED_BIT])
      div_reg <= {1'b1, pwdata[nvmcd_pkg::DIV_PRESCALE_BIT:0]};
  end

  // Prescale by eight gives one tick per eight bus clocks when enabled
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
      pre_cnt_reg <= 3'h0;
    else if (div_reg[nvmcd_pkg::DIV_PRESCALE_BIT])
      pre_cnt_reg <= pre_cnt_reg + 3'h1;
    else
      pre_cnt_reg <= 3'h0;
  end
  assign pre_tick = !div_reg[nvmcd_pkg::DIV_PRESCALE_BIT] ||
                    (pre_cnt_reg == nvmcd_pkg::PRESCALE_LAST);

  // Reload counter of divisor plus one; zero passes ticks straight through
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      div_cnt_reg <= 6'h00;
      nvm_clk_en <= 1'b0;
    end
    else
    begin
      nvm_clk_en <= 1'b0;
      if (pre_tick && div_reg[nvmcd_pkg::DIV_LOADED_BIT])
      begin
        if (div_cnt_reg >= div_reg[nvmcd_pkg::DIV_MSB:0])
        begin
          div_cnt_reg <= 6'h00;
          nvm_clk_en <= 1'b1;
        end
        else
          div_cnt_reg <= div_cnt_reg + 6'h01;
      end
    end
  end

  // Program and erase gate follows the loaded flag
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
      pgm_erase_enable <= 1'b0;
    else
      pgm_erase_enable <= div_reg[nvmcd_pkg::DIV_LOADED_BIT];
  end

  // Option copy is reloaded from the stored byte while reset is held,
  // then the security code may only be opened by key or blank check.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
      opt_reg <= stored_option_byte;
    else if (key_state_reg == nvmcd_pkg::KS_CHECK && key_match_reg
             && opt_reg[nvmcd_pkg::OPT_BACKDOOR_KEY_ENABLE_BIT])
      opt_reg[1:0] <= nvmcd_pkg::SEC_UNSECURED;
    else if (blank_check_ok)
      opt_reg[1:0] <= nvmcd_pkg::SEC_UNSECURED;
  end

  // Key access control bit
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
      key_access_reg <= 1'b0;
    else if (wr_acc && paddr == nvmcd_pkg::ADDR_KEYCTL)
      key_access_reg <= pwdata[0];
  end

  // Key entry: bytes in order while access bit set, compare on its clear
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      key_state_reg <= nvmcd_pkg::KS_IDLE;
      key_idx_reg <= 3'h0;
      key_match_reg <= 1'b0;
    end
    else
    begin
      case (key_state_reg)
        nvmcd_pkg::KS_IDLE:
          if (key_access_reg)
          begin
            key_state_reg <= nvmcd_pkg::KS_ENTER;
            key_idx_reg <= 3'h0;
            key_match_reg <= 1'b1;
          end
        nvmcd_pkg::KS_ENTER:
          if (!key_access_reg)
          begin
            // Access dropped before all eight bytes: short key never matches
            key_state_reg <= nvmcd_pkg::KS_CHECK;
            key_match_reg <= 1'b0;
          end
          else if (wr_acc && paddr == nvmcd_pkg::ADDR_KEY)
          begin
            // Debug-side writes spoil the match so they never unlock
            if (!access_from_secure ||
                pwdata[7:0] != stored_backdoor_key[key_idx_reg*8 +: 8])
              key_match_reg <= 1'b0;
            if (key_idx_reg == nvmcd_pkg::KEY_LAST)
              key_state_reg <= nvmcd_pkg::KS_FAIL;
            else
              key_idx_reg <= key_idx_reg + 3'h1;
          end
        nvmcd_pkg::KS_FAIL:
          // All eight bytes taken; wait for the access bit to drop
          if (!key_access_reg)
            key_state_reg <= nvmcd_pkg::KS_CHECK;
        nvmcd_pkg::KS_CHECK:
        begin
          // Option logic takes the match flag in this cycle
          key_state_reg <= nvmcd_pkg::KS_IDLE;
        end
        default:
          key_state_reg <= nvmcd_pkg::KS_IDLE;
      endcase
    end
  end

  // Key-location writes with access bit clear start a command instead
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
      cmd_start <= 1'b0;
    else
      cmd_start <= wr_acc && paddr == nvmcd_pkg::ADDR_KEY
                   && !key_access_reg
                   && div_reg[nvmcd_pkg::DIV_LOADED_BIT];
  end

  // Memory access gate: secure device blocks unsecured sources
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      mem_grant <= 1'b0;
      mem_rdata <= 8'h00;
    end
    else
    begin
      mem_grant <= mem_req && (!is_secure || mem_from_secure);
      mem_rdata <= (!is_secure || mem_from_secure) ? mem_rdata_raw
                   : 8'h00;
    end
  end

  // Decoded options for the rest of the device
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
      opt_out <= '0;
    else
    begin
      opt_out.key_enable <= opt_reg[nvmcd_pkg::OPT_BACKDOOR_KEY_ENABLE_BIT];
      opt_out.redirection_disable <=
        opt_reg[nvmcd_pkg::OPT_NORED_BIT];
      opt_out.eeprom_sector_mode <=
        opt_reg[nvmcd_pkg::OPT_SECMODE_BIT];
      opt_out.secure <= is_secure;
    end
  end

  // APB read data and handshake; unmapped reads zero with error
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      rst_seen_reg <= 1'b0;
    end
    else
    begin
      rst_seen_reg <= 1'b1;
      pready <= psel && !penable;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      if (psel && !penable)
      begin
        case (paddr)
          nvmcd_pkg::ADDR_DIVIDER: prdata <= {24'h000000, div_reg};
          nvmcd_pkg::ADDR_OPTION: prdata <= {24'h000000, opt_reg};
          nvmcd_pkg::ADDR_KEYCTL: prdata <= {31'h0, key_access_reg};
          nvmcd_pkg::ADDR_STATUS:
            prdata <= {29'h0, pgm_erase_enable, is_secure, rst_seen_reg};
          nvmcd_pkg::ADDR_KEY: prdata <= 32'h0000_0000;
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

  // Checks on the design's own behaviour
  property p_div_once;
    @(posedge sys_clk) disable iff (!rst_b)
    div_reg[nvmcd_pkg::DIV_LOADED_BIT] |=> $stable(div_reg);
  endproperty
  a_div_once: assert property (p_div_once)
    else $error("divider changed after load");

  property p_loaded_set;
    @(posedge sys_clk) disable iff (!rst_b)
    (wr_acc && paddr == nvmcd_pkg::ADDR_DIVIDER)
      |=> div_reg[nvmcd_pkg::DIV_LOADED_BIT];
  endproperty
  a_loaded_set: assert property (p_loaded_set)
    else $error("divider write did not set loaded flag");

  property p_gate;
    @(posedge sys_clk) disable iff (!rst_b)
    !div_reg[nvmcd_pkg::DIV_LOADED_BIT] |=> !pgm_erase_enable && !cmd_start;
  endproperty
  a_gate: assert property (p_gate)
    else $error("program allowed before divider load");

  property p_no_tick_unloaded;
    @(posedge sys_clk) disable iff (!rst_b)
    !div_reg[nvmcd_pkg::DIV_LOADED_BIT] |=> !nvm_clk_en;
  endproperty
  a_no_tick_unloaded: assert property (p_no_tick_unloaded)
    else $error("memory clock ran before load");

  sequence s_tick_div1;
    nvm_clk_en ##1 nvm_clk_en;
  endsequence
  property p_div1_pass;
    @(posedge sys_clk) disable iff (!rst_b)
    (div_reg[7:0] == 8'h80) [*3] |-> s_tick_div1 or ##1 s_tick_div1;
  endproperty
  a_div1_pass: assert property (p_div1_pass)
    else $error("zero divisor did not pass input");

  property p_pre8;
    @(posedge sys_clk) disable iff (!rst_b)
    (nvm_clk_en && div_reg[nvmcd_pkg::DIV_PRESCALE_BIT])
      |=> !nvm_clk_en [*7];
  endproperty
  a_pre8: assert property (p_pre8)
    else $error("prescaled tick came too early");

  property p_blocked_read;
    @(posedge sys_clk) disable iff (!rst_b)
    (is_secure && !mem_from_secure) |=> mem_rdata == 8'h00 && !mem_grant;
  endproperty
  a_blocked_read: assert property (p_blocked_read)
    else $error("secure memory leaked to unsecured source");

  property p_unlock;
    @(posedge sys_clk) disable iff (!rst_b)
    blank_check_ok |=> opt_reg[1:0] == nvmcd_pkg::SEC_UNSECURED;
  endproperty
  a_unlock: assert property (p_unlock)
    else $error("blank check did not unsecure");

  property p_backdoor_key_enable;
    @(posedge sys_clk) disable iff (!rst_b)
    (!opt_reg[nvmcd_pkg::OPT_BACKDOOR_KEY_ENABLE_BIT] && !blank_check_ok)
      |=> $stable(opt_reg[1:0]);
  endproperty
  a_backdoor_key_enable: assert property (p_backdoor_key_enable)
    else $error("security opened without key enable");

  property p_opt_out;
    @(posedge sys_clk) disable iff (!rst_b)
    1'b1 |=> opt_out.redirection_disable ==
             $past(opt_reg[nvmcd_pkg::OPT_NORED_BIT]) &&
             opt_out.eeprom_sector_mode ==
             $past(opt_reg[nvmcd_pkg::OPT_SECMODE_BIT]);
  endproperty
  a_opt_out: assert property (p_opt_out)
    else $error("option outputs do not follow register");
endmodule

// ==== sim/tb_top.sv ====
// Self-checking bench for the nvm clock divider and option block.
// Assumes nvmcd_top answers APB in one access cycle, no wait states.
`timescale 1ns/1ps
module tb_top;
  logic sys_clk = '0;
  logic rst_b = '0;
  logic psel = '0;
  logic penable = '0;
  logic pwrite = '0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [7:0] stored_option_byte = '0;
  logic [63:0] stored_backdoor_key = '0;
  logic access_from_secure = '1;
  logic blank_check_ok = '0;
  logic mem_req = '0;
  logic mem_from_secure = '0;
  logic [7:0] mem_rdata_raw = '0;
  logic mem_grant;
  logic [7:0] mem_rdata;
  logic nvm_clk_en;
  logic pgm_erase_enable;
  logic cmd_start;
  nvmcd_pkg::nvmcd_opt_t opt_out;
  int fails = 0;
  int total_checks = 0;
  int cyc = 0;
  int starts = 0;
  logic [31:0] seed = 32'hb3c8;
  logic [31:0] r;
  logic e;

  nvmcd_top nvmcd_top_inst (.sys_clk, .rst_b, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .stored_option_byte,
    .stored_backdoor_key, .access_from_secure, .blank_check_ok, .mem_req,
    .mem_from_secure, .mem_rdata_raw, .mem_grant, .mem_rdata, .nvm_clk_en,
    .pgm_erase_enable, .cmd_start, .opt_out);

  always #10 sys_clk = ~sys_clk;

  // Pulse counter and hang guard
  always @(posedge sys_clk)
  begin
    if (cmd_start === 1'h1)
      starts++;
    cyc++;
    if (cyc == 60000)
    begin
      fails++;
      test_done();
    end
  end

  task test_done();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Shift register source of stimulus, fixed start
  function logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction

  // One APB transfer; pready is sampled at the rising edge that ends it
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'h1;
    do @(posedge sys_clk); while (pready !== 1'h1);
    r = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  // Reset with a given stored option byte, then check its copy
  task rst(input logic [7:0] o);
    @(posedge sys_clk);
    rst_b <= 1'h0;
    stored_option_byte <= o;
    repeat (12) @(posedge sys_clk);
    rst_b <= 1'h1;
    repeat (2) @(posedge sys_clk);
    apb(1'h0, nvmcd_pkg::ADDR_OPTION, 32'h0);
    chk(r & 32'he3, o & 8'he3);
    chk(opt_out, {o[7:5], o[1:0] != 2'h2});
    chk(pgm_erase_enable, 1'h0);
  endtask

  // Load the divider once, try again, then time the memory clock
  task div(input logic p, input logic [5:0] d);
    int n;
    n = 0;
    apb(1'h1, nvmcd_pkg::ADDR_DIVIDER,
      {24'h0, 8'(rnd() & 32'h80) | {1'h0, p, d}});
    apb(1'h0, nvmcd_pkg::ADDR_DIVIDER, 32'h0);
    chk(r, {24'h0, 1'h1, p, d});
    apb(1'h1, nvmcd_pkg::ADDR_DIVIDER, {25'h0, ~p, ~d});
    apb(1'h0, nvmcd_pkg::ADDR_DIVIDER, 32'h0);
    chk(r, {24'h0, 1'h1, p, d});
    chk(pgm_erase_enable, 1'h1);
    do @(negedge sys_clk); while (nvm_clk_en !== 1'h1);
    do
    begin
      @(negedge sys_clk);
      n++;
    end
    while (nvm_clk_en !== 1'h1);
    chk(n, (int'(d) + 1) * (p ? 8 : 1));
  endtask

  // Memory request from a given source; grant decided by security
  task mem(input logic s, input logic g);
    logic [7:0] v;
    v = 8'(rnd());
    @(posedge sys_clk);
    mem_req <= 1'h1;
    mem_from_secure <= s;
    mem_rdata_raw <= v;
    @(posedge sys_clk);
    @(negedge sys_clk);
    chk(mem_grant, g);
    chk(mem_rdata, g ? v : 8'h0);
    @(posedge sys_clk);
    mem_req <= 1'h0;
  endtask

  // Key entry; case 1 one byte from debug, 3 one wrong byte, 4 seven bytes
  task key(input int k);
    apb(1'h1, nvmcd_pkg::ADDR_KEYCTL, 32'h1);
    for (int i = 0; i < (k == 4 ? 7 : 8); i++)
    begin
      access_from_secure <= !(k == 1 && i == 3);
      apb(1'h1, nvmcd_pkg::ADDR_KEY, {24'h0,
        stored_backdoor_key[8*i +: 8] ^ 8'(k == 3 && i == 5)});
    end
    access_from_secure <= 1'h1;
    apb(1'h1, nvmcd_pkg::ADDR_KEYCTL, 32'h0);
    repeat (6) @(posedge sys_clk);
  endtask

  initial
  begin
    logic [7:0] o;
    logic [31:0] t;
    t = rnd();
    o = {t[7:5], 3'h0, 2'h2};
    rst(o);
    apb(1'h0, nvmcd_pkg::ADDR_STATUS, 32'h0);
    chk(r, 32'h1);
    mem(1'h0, 1'h1);
    apb(1'h1, nvmcd_pkg::ADDR_KEY, t);
    chk(starts, 0);
    apb(1'h0, nvmcd_pkg::ADDR_DIVIDER, 32'h0);
    chk(r, 32'h0);
    // Memory clock 160 to 195 kHz at 50 MHz before any command starts
    div(1'h1, 6'h1f + {3'h0, t[10:8]});
    apb(1'h1, nvmcd_pkg::ADDR_KEY, t);
    repeat (2) @(posedge sys_clk);
    chk(starts, 1);
    apb(1'h0, 12'h020, 32'h0);
    chk(e, 1'h1);
    chk(r, 32'h0);
    // Option copy must not follow the stored byte outside reset
    apb(1'h1, nvmcd_pkg::ADDR_OPTION, {24'h0, ~o});
    stored_option_byte <= ~o;
    apb(1'h0, nvmcd_pkg::ADDR_OPTION, 32'h0);
    chk(r & 32'he3, o & 8'he3);
    // Secure codes 0:0, 0:1, 1:1 and five key outcomes, short key last
    for (int k = 0; k < 5; k++)
    begin
      t = rnd();
      stored_backdoor_key <= {t, rnd()};
      rst({k != 2, t[6:5], 3'h0, 2'(k == 0 ? 0 : k == 1 ? 1 : 3)});
      apb(1'h0, nvmcd_pkg::ADDR_STATUS, 32'h0);
      chk(r, 32'h3);
      mem(1'h0, 1'h0);
      mem(1'h1, 1'h1);
      div(k != 0, k == 0 ? 6'h00 : {3'h0, t[10:8]});
      key(k);
      chk(starts, 1);
      if (k == 2)
      begin
        blank_check_ok <= 1'h1;
        @(posedge sys_clk);
        blank_check_ok <= 1'h0;
        repeat (4) @(posedge sys_clk);
      end
      apb(1'h0, nvmcd_pkg::ADDR_STATUS, 32'h0);
      chk(r, (k == 0 || k == 2) ? 32'h5 : 32'h7);
      mem(1'h0, k == 0 || k == 2);
    end
    test_done();
  end
endmodule
